// File: verilog/bldsf_pkg.sv
// Purpose: constants for the legacy decode and system-error forwarding block
// Assumes: 32-bit addresses on both sides of the bridge
// Notes: all figures shared by the decode leaf and the top live here
package bldsf_pkg;
    // display memory hole, inclusive bounds
    localparam logic [31:0] BLDSF_VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] BLDSF_VGA_MEM_HI = 32'h000B_FFFF;
    // display i/o ports, low ten address bits, inclusive bounds
    localparam logic [9:0] BLDSF_VGA_IO1_LO = 10'h3B0;
    localparam logic [9:0] BLDSF_VGA_IO1_HI = 10'h3BB;
    localparam logic [9:0] BLDSF_VGA_IO2_LO = 10'h3C0;
    localparam logic [9:0] BLDSF_VGA_IO2_HI = 10'h3DF;
    // upper half of the i/o address must be zero (first 64 KB)
    localparam logic [15:0] BLDSF_IO_HI_ZERO = 16'h0000;
    // isa alias: offsets 0x100..0x3FF in each 1 KB block, i.e. bits 9:8 nonzero
    localparam logic [1:0] BLDSF_ISA_LOW_QTR = 2'h0;
    // control bit reset values
    localparam logic BLDSF_CTL_RST = 1'b0;
    // message severity codes on the error message port
    typedef enum logic {BLDSF_SEV_NONFATAL, BLDSF_SEV_FATAL} bldsf_sev_t;
    // error forwarding states
    typedef enum logic [1:0] {BLDSF_ERR_IDLE, BLDSF_ERR_SEND, BLDSF_ERR_HOLD} bldsf_err_st_t;
endpackage

// File: verilog/bldsf_decode.sv
// Purpose: address classification for display and isa alias ranges
// Assumes: address is the full 32-bit request address
// Notes: pure combinational leaf, used for both directions
`timescale 1ns/1ps
module bldsf_decode
    import bldsf_pkg::*;
(
    input wire logic [31:0] addr,
    input wire logic is_io,
    output logic vga_hit,
    output logic isa_alias
);
    // display i/o match on the low ten bits only
    function automatic logic io_port_hit(input logic [9:0] a);
        io_port_hit = ((a >= BLDSF_VGA_IO1_LO) && (a <= BLDSF_VGA_IO1_HI))
                   || ((a >= BLDSF_VGA_IO2_LO) && (a <= BLDSF_VGA_IO2_HI));
    endfunction

    logic low64k; // address within first 64 KB of i/o space

    // classification
    always_comb begin
        low64k = (addr[31:16] == BLDSF_IO_HI_ZERO);
        if (is_io) begin
            // bits 15:10 ignored so every alias matches
            vga_hit = low64k && io_port_hit(addr[9:0]);
        end else begin
            vga_hit = (addr >= BLDSF_VGA_MEM_LO) && (addr <= BLDSF_VGA_MEM_HI);
        end
        // top 768 bytes of a 1 KB block, first 64 KB only
        isa_alias = is_io && low64k && (addr[9:8] != BLDSF_ISA_LOW_QTR);
    end
endmodule // bldsf_decode

// File: verilog/bldsf_top.sv
// Purpose: forwarding qualification for legacy display and isa aliased
//          addresses, and conversion of secondary system errors to messages
// Assumes: window comparators and command enables are computed elsewhere
// Notes: decisions are registered one cycle after the request strobe
//
// How it works
// - display memory hole forwarded downstream when enabled
// - display i/o ports forwarded downstream when enabled
// - display i/o needs high bits zero, aliases
// - display ranges never forwarded upstream when enabled
// - display forwarding ignores isa bit and windows
// - display forwarding gated by space enables
// - display disabled: forward only inside windows
// - alias filter only inside window, first 64k
// - filter on: block downstream alias addresses
// - filter on: forward upstream alias addresses
// - filter off: forward whole i/o window
// - pin asserted and enabled: send error message
// - aer mask must be clear to forward
// - enable clear: forward only if unmasked
`timescale 1ns/1ps
module bldsf_top
    import bldsf_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    // software control writes
    input wire logic ctl_wr,
    input wire logic vga_fwd_en_wdata,
    input wire logic isa_alias_filter_en_wdata,
    input wire logic sys_err_fwd_en_wdata,
    output logic vga_fwd_en,
    output logic isa_alias_filter_en,
    output logic sys_err_fwd_en,
    // context from the rest of the bridge
    input wire logic io_space_en,
    input wire logic mem_space_en,
    input wire logic aer_supported,
    input wire logic sec_serr_mask,
    input wire logic serr_fatal_sel,
    // request to qualify
    input wire logic req_valid,
    input wire logic req_upstream,
    input wire logic req_is_io,
    input wire logic [31:0] req_addr,
    input wire logic in_io_window,
    input wire logic in_mem_window,
    output logic fwd_valid,
    output logic fwd_accept,
    // secondary error pin, active low
    input wire logic secondary_sys_err_pin_n,
    // error message request to the link layer
    output logic err_msg_valid,
    output logic err_msg_fatal,
    input wire logic err_msg_ready
);
    ////////////////////////////////////////////////////////////////////
    // control bits
    logic vga_r, vga_nxt;
    logic isa_r, isa_nxt;
    logic serr_r, serr_nxt;

    // software writes all three at once
    always_comb begin
        vga_nxt = vga_r;
        isa_nxt = isa_r;
        serr_nxt = serr_r;
        if (ctl_wr) begin
            vga_nxt = vga_fwd_en_wdata;
            isa_nxt = isa_alias_filter_en_wdata;
            serr_nxt = sys_err_fwd_en_wdata;
        end
    end

    // reset to cleared
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vga_r <= BLDSF_CTL_RST;
            isa_r <= BLDSF_CTL_RST;
            serr_r <= BLDSF_CTL_RST;
        end else begin
            vga_r <= vga_nxt;
            isa_r <= isa_nxt;
            serr_r <= serr_nxt;
        end
    end

    // outputs straight from the registers, no decode behind them
    assign vga_fwd_en = vga_r;
    assign isa_alias_filter_en = isa_r;
    assign sys_err_fwd_en = serr_r;

    ////////////////////////////////////////////////////////////////////
    // forwarding decision
    logic vga_hit; // request lands in a display range
    logic isa_alias; // request is an isa alias address
    logic space_ok; // matching command space enable
    logic accept_c; // combinational decision
    logic fv_r, fv_nxt;
    logic fa_r, fa_nxt;

    // decode leaf shared by both directions
    bldsf_decode bldsf_decode_i (
        .addr(req_addr),
        .is_io(req_is_io),
        .vga_hit(vga_hit),
        .isa_alias(isa_alias)
    );

    // decision priority: display rules first, then windows with alias filter
    always_comb begin
        space_ok = req_is_io ? io_space_en : mem_space_en;
        accept_c = 1'b0;
        if (!req_upstream) begin
            if (vga_r && vga_hit) begin
                // windows and isa bit play no part here
                accept_c = space_ok;
            end else if (req_is_io) begin
                // alias filter only bites inside the window
                if (isa_r && isa_alias && in_io_window) begin
                    accept_c = 1'b0;
                end else begin
                    accept_c = in_io_window && io_space_en;
                end
            end else begin
                accept_c = in_mem_window && mem_space_en;
            end
        end else begin
            // upstream: claim what is not ours below
            if (vga_r && vga_hit) begin
                accept_c = 1'b0;
            end else if (req_is_io) begin
                // filtered aliases go up even inside the window
                accept_c = !in_io_window || (isa_r && isa_alias);
            end else begin
                accept_c = !in_mem_window;
            end
        end
        fv_nxt = req_valid;
        fa_nxt = req_valid && accept_c;
    end

    // registered decision, one cycle after the request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fv_r <= 1'b0;
            fa_r <= 1'b0;
        end else begin
            fv_r <= fv_nxt;
            fa_r <= fa_nxt;
        end
    end

    // decision shows for exactly one cycle
    assign fwd_valid = fv_r;
    assign fwd_accept = fa_r;

    ////////////////////////////////////////////////////////////////////
    // secondary system error forwarding
    bldsf_err_st_t st_r, st_nxt;
    logic fatal_r, fatal_nxt;
    logic serr_allow; // forwarding permitted right now
    logic serr_act; // pin asserted

    // one message per assertion; hold until the pin releases so a long
    // low level does not flood the link
    always_comb begin
        serr_act = !secondary_sys_err_pin_n;
        // mask clear under aer may forward even with enable off
        serr_allow = aer_supported ? (!sec_serr_mask) : serr_r;
        st_nxt = st_r;
        fatal_nxt = fatal_r;
        case (st_r)
            BLDSF_ERR_IDLE: begin
                if (serr_act && serr_allow) begin
                    st_nxt = BLDSF_ERR_SEND;
                    // severity selectable only with aer
                    fatal_nxt = aer_supported && serr_fatal_sel;
                end
            end
            BLDSF_ERR_SEND: begin
                if (err_msg_ready) begin
                    st_nxt = BLDSF_ERR_HOLD;
                end
            end
            BLDSF_ERR_HOLD: begin
                // rearm only once the pin has released
                if (!serr_act) begin
                    st_nxt = BLDSF_ERR_IDLE;
                end
            end
            default: begin
                st_nxt = BLDSF_ERR_IDLE;
            end
        endcase
    end

    // error state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= BLDSF_ERR_IDLE;
            fatal_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            fatal_r <= fatal_nxt;
        end
    end

    // valid comes from the state alone, so it cannot glitch with the pin
    assign err_msg_valid = (st_r == BLDSF_ERR_SEND);
    assign err_msg_fatal = fatal_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    // decisions are looked at one edge after the request that caused them
    ctl_reset_a: assert property (@(posedge clk)
        $rose(arst_n) |-> !vga_r && !isa_r && !serr_r)
        else $error("control bits not cleared by reset");

    ctl_write_a: assert property (@(posedge clk) disable iff (!arst_n)
        ctl_wr |=> (vga_fwd_en == $past(vga_fwd_en_wdata))
                   && (isa_alias_filter_en == $past(isa_alias_filter_en_wdata))
                   && (sys_err_fwd_en == $past(sys_err_fwd_en_wdata)))
        else $error("control write not stored");

    vga_down_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && !req_upstream && vga_r && vga_hit && space_ok |=> fwd_accept)
        else $error("display request not forwarded");

    vga_space_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && req_is_io && !io_space_en && !req_upstream |=> !fwd_accept)
        else $error("i/o forwarded with space disabled");

    vga_up_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && req_upstream && vga_r && vga_hit |=> fwd_valid && !fwd_accept)
        else $error("display range forwarded upstream");

    vga_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && !req_upstream && !vga_r && !req_is_io && !in_mem_window
        |=> !fwd_accept)
        else $error("memory outside window forwarded");

    isa_block_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && !req_upstream && isa_r && isa_alias && in_io_window
        && !(vga_r && vga_hit) |=> !fwd_accept)
        else $error("isa alias forwarded downstream");

    isa_up_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && req_upstream && isa_r && isa_alias && !(vga_r && vga_hit)
        |=> fwd_accept)
        else $error("isa alias not forwarded upstream");

    isa_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && !req_upstream && !isa_r && req_is_io && in_io_window
        && io_space_en |=> fwd_accept)
        else $error("window i/o not forwarded");

    serr_send_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r == BLDSF_ERR_IDLE) && !secondary_sys_err_pin_n && serr_allow
        |=> err_msg_valid)
        else $error("error message not raised");

    serr_block_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r == BLDSF_ERR_IDLE) && !aer_supported && !serr_r |=> !err_msg_valid)
        else $error("error forwarded while disabled");

    serr_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r == BLDSF_ERR_IDLE) && aer_supported && sec_serr_mask |=> !err_msg_valid)
        else $error("masked error forwarded");

    isa_high_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && !req_upstream && req_is_io && isa_r && in_io_window && io_space_en
        && (req_addr[31:16] != BLDSF_IO_HI_ZERO) |=> fwd_accept)
        else $error("i/o above first 64k filtered");

    vga_alias_a: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && !req_upstream && req_is_io && vga_r && io_space_en
        && (req_addr[31:16] == BLDSF_IO_HI_ZERO) && (req_addr[9:0] == BLDSF_VGA_IO2_LO)
        |=> fwd_accept)
        else $error("display i/o alias not forwarded");

    msg_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        err_msg_valid && !err_msg_ready |=> err_msg_valid && $stable(err_msg_fatal))
        else $error("error message dropped before taken");

    msg_once_a: assert property (@(posedge clk) disable iff (!arst_n)
        err_msg_valid && err_msg_ready |=> !err_msg_valid)
        else $error("error message repeated");

    // covers of the main scenarios
    vga_fwd_c: cover property (@(posedge clk) disable iff (!arst_n)
        req_valid && vga_r && vga_hit && !req_upstream ##1 fwd_accept);
    isa_blk_c: cover property (@(posedge clk) disable iff (!arst_n)
        req_valid && isa_r && isa_alias && in_io_window && !req_upstream ##1 !fwd_accept);
    serr_msg_c: cover property (@(posedge clk) disable iff (!arst_n)
        err_msg_valid && err_msg_ready ##1 (st_r == BLDSF_ERR_HOLD));
    isa_up_c: cover property (@(posedge clk) disable iff (!arst_n)
        req_valid && req_upstream && isa_r && isa_alias ##1 fwd_accept);
    fatal_msg_c: cover property (@(posedge clk) disable iff (!arst_n)
        err_msg_valid && err_msg_fatal && err_msg_ready);
endmodule // bldsf_top

// File: test/bldsf_link_model.sv
// Purpose: link layer stand-in that takes error messages from the block
// Assumes: one message is taken on the edge where valid and ready are both high
// Notes: ready_dly sets how many cycles a message waits before it is taken
`timescale 1ns/1ps
module bldsf_link_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic err_msg_valid,
    input wire logic err_msg_fatal,
    input wire logic [3:0] ready_dly,
    output logic err_msg_ready,
    output logic [7:0] msg_cnt,
    output logic last_fatal
);
    logic [3:0] wait_cnt; // cycles the current message has waited
    ////////////////////////////////////////////////////////////////////////
    // ready pulses once per message, late when ready_dly is large,
    // so the block must hold valid through a stalled link
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            err_msg_ready <= 1'b0;
            wait_cnt <= 4'h0;
            msg_cnt <= 8'h00;
            last_fatal <= 1'b0;
        end else if (err_msg_ready) begin
            // message taken at this edge
            err_msg_ready <= 1'b0;
            wait_cnt <= 4'h0;
            if (err_msg_valid) begin
                msg_cnt <= msg_cnt + 8'h01;
                last_fatal <= err_msg_fatal;
            end
        end else if (err_msg_valid) begin
            // stall until the chosen delay has run out
            if (wait_cnt == ready_dly) begin
                err_msg_ready <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule // bldsf_link_model

// File: test/tb_bldsf_top.sv
// Purpose: directed bench for display decode, alias filter and error messages
// Assumes: decisions show one cycle after the request strobe
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_bldsf_top;
    import bldsf_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, ctl_wr = 1'b0, wv = 1'b0, wi = 1'b0, ws = 1'b0;
    logic io_en = 1'b1, mem_en = 1'b1, aer = 1'b0, mask = 1'b1, fsel = 1'b0;
    logic rv = 1'b0, up = 1'b0, isio = 1'b0, iw = 1'b0, mw = 1'b0, pin_n = 1'b1;
    logic [31:0] addr = 32'h0000_0000;
    logic [3:0] dly = 4'h0;
    logic vga, isa, serr, fv, fa, emv, emf, emr, lastf;
    logic [7:0] msgs;
    int error_cnt = 0, n_tests = 0;
    always #50 clk = ~clk; // 10 MHz
    bldsf_top bldsf_top_i (.clk(clk), .arst_n(arst_n), .ctl_wr(ctl_wr),
        .vga_fwd_en_wdata(wv), .isa_alias_filter_en_wdata(wi), .sys_err_fwd_en_wdata(ws),
        .vga_fwd_en(vga), .isa_alias_filter_en(isa), .sys_err_fwd_en(serr),
        .io_space_en(io_en), .mem_space_en(mem_en), .aer_supported(aer),
        .sec_serr_mask(mask), .serr_fatal_sel(fsel), .req_valid(rv), .req_upstream(up),
        .req_is_io(isio), .req_addr(addr), .in_io_window(iw), .in_mem_window(mw),
        .fwd_valid(fv), .fwd_accept(fa), .secondary_sys_err_pin_n(pin_n),
        .err_msg_valid(emv), .err_msg_fatal(emf), .err_msg_ready(emr));
    bldsf_link_model bldsf_link_model_i (.clk(clk), .arst_n(arst_n),
        .err_msg_valid(emv), .err_msg_fatal(emf), .ready_dly(dly),
        .err_msg_ready(emr), .msg_cnt(msgs), .last_fatal(lastf));
    ////////////////////////////////////////////////////////////////////////
    // compare and report one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // software write of the three control bits, then read back
    task automatic wr(input logic v, input logic i, input logic s);
        @(posedge clk) #1 {ctl_wr, wv, wi, ws} = {1'b1, v, i, s};
        @(posedge clk) #1 ctl_wr = 1'b0;
        chk("control bits", {v, i, s}, {vga, isa, serr});
    endtask
    // one request; decision expected one cycle later
    task automatic req(input logic u, input logic io, input logic [31:0] a,
                       input logic w_io, input logic w_mem, input logic exp);
        @(posedge clk) #1 {rv, up, isio, addr, iw, mw} = {1'b1, u, io, a, w_io, w_mem};
        @(posedge clk) #1 rv = 1'b0;
        chk("decision valid", 1'b1, fv);
        chk("accept", exp, fa);
    endtask
    // hold the error pin low for 20 cycles; one message at most per assertion
    task automatic sec_err(input logic [3:0] d, input logic [7:0] n, input logic f);
        @(posedge clk) #1 {dly, pin_n} = {d, 1'b0};
        repeat (20) @(posedge clk);
        #1 pin_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("message count", n, msgs);
        chk("message severity", f, lastf);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #(3000 * 100);
        error_cnt++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1 arst_n = 1'b1;
        chk("reset state", 5'h00, {vga, isa, serr, fv, emv});
        wr(1'b1, 1'b0, 1'b0);
        req(0, 0, 32'h000A_0000, 0, 0, 1);
        req(0, 0, 32'h000B_FFFF, 0, 0, 1);
        req(0, 0, 32'h0009_FFFF, 0, 0, 0);
        req(0, 1, 32'h0000_03B0, 0, 0, 1);
        req(0, 1, 32'h0000_03BB, 0, 0, 1);
        req(0, 1, 32'h0000_03BC, 0, 0, 0);
        req(0, 1, 32'h0000_03DF, 0, 0, 1);
        req(0, 1, 32'h0000_FBC0, 0, 0, 1);
        req(0, 1, 32'h0001_03C0, 0, 0, 0);
        req(1, 0, 32'h000A_0000, 0, 0, 0);
        req(1, 1, 32'h0000_03C0, 0, 0, 0);
        mem_en = 1'b0;
        req(0, 0, 32'h000A_0000, 0, 1, 0);
        {mem_en, io_en} = 2'b10;
        req(0, 1, 32'h0000_03B0, 1, 0, 0);
        io_en = 1'b1;
        wr(1'b1, 1'b1, 1'b0);
        req(0, 1, 32'h0000_03C0, 1, 0, 1);
        wr(1'b0, 1'b1, 1'b0);
        req(0, 0, 32'h000A_0000, 0, 1, 1);
        req(0, 0, 32'h000A_0000, 0, 0, 0);
        req(0, 1, 32'h0000_03C0, 0, 0, 0);
        req(1, 0, 32'h000A_0000, 0, 0, 1);
        req(1, 0, 32'h000A_0000, 0, 1, 0);
        req(0, 1, 32'h0000_0100, 1, 0, 0);
        req(0, 1, 32'h0000_07FF, 1, 0, 0);
        req(0, 1, 32'h0000_04FF, 1, 0, 1);
        req(0, 1, 32'h0001_0100, 1, 0, 1);
        req(0, 1, 32'h0000_0100, 0, 0, 0);
        req(1, 1, 32'h0000_0100, 1, 0, 1);
        req(1, 1, 32'h0000_00FF, 1, 0, 0);
        wr(1'b0, 1'b0, 1'b0);
        req(0, 1, 32'h0000_0100, 1, 0, 1);
        req(0, 1, 32'h0000_0300, 1, 0, 1);
        req(1, 1, 32'h0000_0100, 1, 0, 0);
        wr(1'b0, 1'b0, 1'b1);
        sec_err(4'h0, 8'h01, 1'b0);
        fsel = 1'b1;
        sec_err(4'h6, 8'h02, 1'b0);
        wr(1'b0, 1'b0, 1'b0);
        sec_err(4'h0, 8'h02, 1'b0);
        {aer, mask} = 2'b10;
        sec_err(4'h3, 8'h03, 1'b1);
        mask = 1'b1;
        wr(1'b0, 1'b0, 1'b1);
        sec_err(4'h0, 8'h03, 1'b1);
        test_done();
    end
endmodule // tb_bldsf_top
